// File: design/ssio_core.sv
`timescale 1ns/1ps
// What this block does
// (R1) Unbuffered clock-out: write shifts 8 bits, then irq
// (R2) Buffered: b1_reg loads shifter, irq on transfer into b1_reg
// (R3) Buffered clock-out: empty buffer stops clock, no irq
// (R4) Clock-in: first programmed edge starts shifting out
// (R5) Host loads frame before external clock starts
// (R6) Buffered clock-in: late write gives underrun, 0xFF
// (R7) Unbuffered clock-out receive: read triggers next frame
// (R8) Clock-out receive runs only with receive enable
// (R9) Received frame moves to buffer 2, irq
// (R10) Unread buffer 2 stalls clock; read resumes it
// (R11) Clock-in receive always buffered, irq per transfer
// (R12) Software sets receive enable before receiving
// (R13) Full-duplex bit sends and receives together
// (R14) Full-duplex unbuffered: write runs one exchange
// (R15) Next exchange needs read and write, any order
// (R16) Full-duplex buffered: write starts, reload after send
// (R17) Full-duplex buffered: stall on empty or full
// (R18) Full-duplex clock-in shifts on programmed edge
// (R19) Host keeps pace with external clock
// (R20) Clock-in: unread buffer 2 at frame end overruns
// (R21) Error flags stick until software clears them
module ssio_core #(
	parameter int FIFO_DEPTH = ssio_pkg::RX_FIFO_DEPTH,
	parameter int HALF_CYC   = ssio_pkg::SCLK_HALF_CYC
) (
	// Clock and reset
	input  wire logic                CLK_I,
	input  wire logic                RESET_I,
	// Configuration and status
	input  wire ssio_pkg::ssio_cfg_t CFG_I,
	input  wire logic                ERR_CLEAR_I,
	output ssio_pkg::ssio_stat_t     STATUS_O,
	// Transmit write side
	input  wire logic [7:0]          TX_DATA_I,
	input  wire logic                TX_VALID_I,
	output logic                     TX_READY_O,
	// Receive read side
	output logic [7:0]               RX_DATA_O,
	output logic                     RX_VALID_O,
	input  wire logic                RX_READY_I,
	// Events
	output logic                     TRANSMIT_INTERRUPT_O,
	output logic                     RECEIVE_INTERRUPT_O,
	// Serial pins
	input  wire logic                SERIAL_CLOCK_PIN_I,
	output logic                     SERIAL_CLOCK_PIN_O,
	output logic                     SERIAL_CLOCK_PIN_OE_O,
	output logic                     TX_DATA_PIN_O,
	input  wire logic                RX_DATA_PIN_I
);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int DW = $clog2(HALF_CYC + 1);

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// =========================================================
	// Declarations
	ssio_pkg::ssio_state_t                state_reg;
	ssio_pkg::ssio_state_t                state_next;
	logic [2:0]                           sclk_sync_reg;
	logic [1:0]                           rxd_sync_reg;
	logic [DW-1:0]                        div_reg;
	logic                                 sclk_reg;
	logic [ssio_pkg::CNT_W-1:0]           bit_cnt_reg;
	logic [7:0]                           hold_reg;
	logic                                 hold_valid_reg;
	logic [7:0]                           b1_reg;
	logic                                 b1_full_reg;
	logic [7:0]                           tx_sh_reg;
	logic [7:0]                           rx_sh_reg;
	logic                                 tx_act_reg;
	logic                                 rx_act_reg;
	logic                                 rx_pend_reg;
	logic                                 txd_reg;
	logic                                 tx_irq_reg;
	logic                                 rx_irq_reg;
	logic                                 underrun_reg;
	logic                                 overrun_reg;
	logic [7:0]                           fifo_mem [FIFO_DEPTH];
	logic [PW-1:0]                        wr_ptr_reg;
	logic [PW-1:0]                        rd_ptr_reg;
	logic [CW-1:0]                        count_reg;

	// =========================================================
	// Pin synchronisers and edge finding
	wire ext_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	wire ext_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	wire ext_edge = CFG_I.rising_edge_select ? ext_rise : ext_fall;
	wire rxd      = rxd_sync_reg[1];

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			sclk_sync_reg <= ssio_pkg::SCLK_SYNC_RST;
			rxd_sync_reg  <= ssio_pkg::RXD_SYNC_RST;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], SERIAL_CLOCK_PIN_I};
			rxd_sync_reg  <= {rxd_sync_reg[0], RX_DATA_PIN_I};
		end
	end

	// =========================================================
	// Mode decode
	wire clk_out    = CFG_I.clock_output_mode;
	wire db         = CFG_I.double_buffer_enable;
	wire fdx        = CFG_I.full_duplex_enable;
	wire rx_en      = CFG_I.receive_enable_bit;
	wire is_run     = (state_reg == ssio_pkg::SH_RUN);
	wire fifo_empty = (count_reg == '0);
	wire fifo_full  = (count_reg == CW'(FIFO_DEPTH));
	// Half duplex picks its direction from the receive enable
	wire tx_sel     = fdx | ~rx_en; // R13
	wire rx_sel     = rx_en; // R12

	// =========================================================
	// Frame start conditions
	wire tx_ok    = db ? b1_full_reg : hold_valid_reg; // R3 R17
	// Unbuffered receive waits for the host read
	wire rx_ok    = ~rx_pend_reg & (db | fifo_empty); // R7
	wire start_ok = fdx ? (tx_ok & rx_ok) : (rx_en ? rx_ok : tx_ok); // R15
	wire run_out  = is_run & clk_out;
	wire tick     = run_out & (div_reg == DW'(HALF_CYC - 1));
	wire shift_ev  = clk_out ? (tick & sclk_reg) : ext_edge; // R18
	wire sample_ev = clk_out ? (tick & ~sclk_reg) : ext_edge;
	// Output mode starts on its own; input mode on the first edge
	wire start_ev = ~is_run & (clk_out ? start_ok : ext_edge); // R4
	wire active   = is_run | start_ev;
	wire done_ev  = sample_ev & is_run
		& (bit_cnt_reg == ssio_pkg::CNT_W'(ssio_pkg::FRAME_BITS - 1));

	// =========================================================
	// Transmit path
	wire tx_done = done_ev & tx_act_reg;
	wire hold_wr = TX_VALID_I & ~hold_valid_reg;
	// Missing data still yields a full frame of ones
	wire [7:0] load_val = db ? (b1_full_reg ? b1_reg : ssio_pkg::DUMMY_BYTE)
		: (hold_valid_reg ? hold_reg : ssio_pkg::DUMMY_BYTE); // R6
	wire hold_take = start_ev & ~db & tx_sel & hold_valid_reg; // R1
	wire load_ev   = db & hold_valid_reg & (~b1_full_reg | tx_done); // R2
	wire underrun_set = start_ev & ~clk_out & db & tx_sel & ~b1_full_reg; // R6
	wire tx_go  = start_ev ? tx_sel : tx_act_reg;
	wire [7:0] tx_cur = start_ev ? load_val : tx_sh_reg;
	wire tx_irq = db ? load_ev : tx_done; // R14

	// =========================================================
	// Receive path
	wire rx_go    = start_ev ? rx_sel : rx_act_reg;
	wire [7:0] rx_word = {rxd, rx_sh_reg[7:1]};
	wire rx_last  = done_ev & rx_act_reg;
	wire push_req = rx_last | rx_pend_reg;
	wire [7:0] push_data = rx_pend_reg ? rx_sh_reg : rx_word;
	wire push     = push_req & ~fifo_full; // R11
	wire pop      = RX_READY_I & ~fifo_empty;
	// A frame held back in output mode waits, input mode drops it
	wire pend_set = rx_last & fifo_full & clk_out; // R10
	wire overrun_set = rx_last & fifo_full & ~clk_out; // R20

	// =========================================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ssio_pkg::SH_IDLE: begin
				if (start_ev) begin
					state_next = ssio_pkg::SH_RUN;
				end
			end
			ssio_pkg::SH_RUN: begin
				if (done_ev) begin
					state_next = ssio_pkg::SH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state_reg   <= ssio_pkg::SH_IDLE;
			bit_cnt_reg <= '0;
			tx_act_reg  <= 1'b0;
			rx_act_reg  <= 1'b0;
			tx_sh_reg   <= ssio_pkg::BYTE_RST;
		end else begin
			state_reg <= state_next;
			if (sample_ev && active) begin
				bit_cnt_reg <= done_ev ? '0 : bit_cnt_reg + 1'b1; // R6
			end
			if (start_ev) begin
				tx_act_reg <= tx_sel;
				rx_act_reg <= rx_sel; // R8
				tx_sh_reg  <= load_val;
			end
		end
	end

	// =========================================================
	// Serial clock generator
	always_ff @(posedge CLK_I) begin
		if (RESET_I || !run_out) begin
			div_reg  <= '0;
			sclk_reg <= ssio_pkg::SCLK_IDLE; // R3
		end else if (tick) begin
			div_reg  <= '0;
			sclk_reg <= ~sclk_reg;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// =========================================================
	// Shifters
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			txd_reg   <= ssio_pkg::TXD_IDLE;
			rx_sh_reg <= ssio_pkg::BYTE_RST;
		end else begin
			if (shift_ev && active && tx_go) begin
				txd_reg <= tx_cur[bit_cnt_reg[2:0]]; // R1
			end
			if (sample_ev && active && rx_go) begin
				rx_sh_reg <= rx_word;
			end
		end
	end

	// =========================================================
	// Transmit buffers
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			hold_reg       <= ssio_pkg::BYTE_RST;
			hold_valid_reg <= 1'b0;
			b1_reg         <= ssio_pkg::BYTE_RST;
			b1_full_reg    <= 1'b0;
		end else begin
			if (hold_wr) begin
				hold_reg       <= TX_DATA_I;
				hold_valid_reg <= 1'b1;
			end else if (hold_take || load_ev) begin
				hold_valid_reg <= 1'b0;
			end
			if (load_ev) begin
				b1_reg      <= hold_reg; // R16
				b1_full_reg <= 1'b1;
			end else if (tx_done && db) begin
				b1_full_reg <= 1'b0;
			end
		end
	end

	// =========================================================
	// Receive buffer 2 queue, events and errors
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			count_reg    <= '0;
			rx_pend_reg  <= 1'b0;
			tx_irq_reg   <= 1'b0;
			rx_irq_reg   <= 1'b0;
			underrun_reg <= 1'b0;
			overrun_reg  <= 1'b0;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				fifo_mem[i] <= ssio_pkg::BYTE_RST;
			end
		end else begin
			if (push) begin
				fifo_mem[wr_ptr_reg] <= push_data; // R9
				wr_ptr_reg           <= ptr_inc(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
			rx_pend_reg  <= pend_set | (rx_pend_reg & ~push); // R10
			tx_irq_reg   <= tx_irq;
			rx_irq_reg   <= push; // R9
			// Set wins over a clear in the same cycle
			underrun_reg <= underrun_set | (underrun_reg & ~ERR_CLEAR_I); // R21
			overrun_reg  <= overrun_set | (overrun_reg & ~ERR_CLEAR_I); // R21
		end
	end

	// =========================================================
	// Outputs
	assign TX_READY_O            = ~hold_valid_reg;
	assign RX_DATA_O             = fifo_mem[rd_ptr_reg];
	assign RX_VALID_O            = ~fifo_empty;
	assign TRANSMIT_INTERRUPT_O  = tx_irq_reg;
	assign RECEIVE_INTERRUPT_O   = rx_irq_reg;
	assign SERIAL_CLOCK_PIN_O    = sclk_reg;
	assign SERIAL_CLOCK_PIN_OE_O = clk_out;
	assign TX_DATA_PIN_O         = txd_reg;
	assign STATUS_O = {~hold_valid_reg, ~fifo_empty, underrun_reg, overrun_reg};

	// =========================================================
	// Checks
	tx_irq_plain_a: assert property ( // R1
		@(posedge CLK_I) disable iff (RESET_I)
		(done_ev && tx_act_reg && !db) |=> TRANSMIT_INTERRUPT_O)
		else $error("no transmit irq after unbuffered frame");
	tx_irq_load_a: assert property ( // R2
		@(posedge CLK_I) disable iff (RESET_I)
		load_ev |=> (TRANSMIT_INTERRUPT_O && b1_full_reg && TX_READY_O))
		else $error("buffer transfer without irq or empty flag");
	tx_stop_a: assert property ( // R3
		@(posedge CLK_I) disable iff (RESET_I)
		(clk_out && db && tx_done && !hold_valid_reg && !fdx && !rx_en)
		|=> (!TRANSMIT_INTERRUPT_O && !is_run))
		else $error("clock kept running with empty buffer");
	dummy_send_a: assert property ( // R6
		@(posedge CLK_I) disable iff (RESET_I)
		underrun_set |=> (underrun_reg && tx_sh_reg == ssio_pkg::DUMMY_BYTE
			&& bit_cnt_reg == 4'h1))
		else $error("underrun not flagged or not dummy");
	rx_enable_a: assert property ( // R8
		@(posedge CLK_I) disable iff (RESET_I)
		(start_ev && clk_out && !rx_en) |=> !rx_act_reg)
		else $error("receive ran without enable");
	rx_move_a: assert property ( // R9
		@(posedge CLK_I) disable iff (RESET_I)
		push |=> (RECEIVE_INTERRUPT_O && RX_VALID_O))
		else $error("received frame not moved with irq");
	rx_stall_a: assert property ( // R10
		@(posedge CLK_I) disable iff (RESET_I)
		(rx_pend_reg && clk_out) |-> (!start_ev && !RECEIVE_INTERRUPT_O))
		else $error("clock started with frame pending");
	fd_stall_a: assert property ( // R17
		@(posedge CLK_I) disable iff (RESET_I)
		(clk_out && fdx && db && (!b1_full_reg || rx_pend_reg)) |-> !start_ev)
		else $error("full duplex clock not halted");
	overrun_a: assert property ( // R20
		@(posedge CLK_I) disable iff (RESET_I)
		(done_ev && rx_act_reg && fifo_full && !clk_out) |=> (overrun_reg && fifo_full))
		else $error("overrun not flagged");
	err_hold_a: assert property ( // R21
		@(posedge CLK_I) disable iff (RESET_I)
		(overrun_reg && !ERR_CLEAR_I) |=> overrun_reg)
		else $error("overrun flag lost without clear");
	first_bit_a: assert property ( // R4
		@(posedge CLK_I) disable iff (RESET_I)
		(start_ev && !clk_out && tx_sel) |=> (TX_DATA_PIN_O == $past(tx_cur[0]) && is_run))
		else $error("first bit not sent on first edge");
endmodule

// File: include/ssio_pkg.sv
package ssio_pkg;
	// =========================================================
	// Frame and timing
	localparam int          FRAME_BITS    = 8;
	localparam int          CNT_W         = 4;
	localparam logic [7:0]  DUMMY_BYTE    = 8'hFF;
	localparam int          CLK_MHZ       = 25;
	localparam int          SCLK_HALF_NS  = 160;
	localparam int          SCLK_HALF_CYC = ((SCLK_HALF_NS * CLK_MHZ + 999) / 1000 < 1) ? 1
		: (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int          RX_FIFO_DEPTH = 2;

	// =========================================================
	// Reset values
	localparam logic        TXD_IDLE      = 1'b1;
	localparam logic        SCLK_IDLE     = 1'b1;
	localparam logic [2:0]  SCLK_SYNC_RST = 3'h7;
	localparam logic [1:0]  RXD_SYNC_RST  = 2'h3;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

	// =========================================================
	// Carriers
	typedef struct packed {
		logic clock_output_mode;
		logic double_buffer_enable;
		logic full_duplex_enable;
		logic receive_enable_bit;
		logic rising_edge_select;
	} ssio_cfg_t;

	typedef struct packed {
		logic tx_buffer_empty_flag;
		logic rx_buffer_full_flag;
		logic underrun_error;
		logic overrun_error;
	} ssio_stat_t;

	typedef enum logic {
		SH_IDLE = 1'b0,
		SH_RUN  = 1'b1
	} ssio_state_t;
endpackage

// File: dv/ssio_peer.sv
`timescale 1ns/1ps
module ssio_peer (
	// Device side
	input  wire logic sclk_dev_i,
	input  wire logic sclk_oe_i,
	input  wire logic txd_i,
	// Peer drive
	output logic      sclk_o,
	output logic      rxd_o
);
	logic [7:0] rot;
	logic [7:0] cap;

	initial begin
		sclk_o = 1'b1;
		rxd_o = 1'b1;
		rot = 8'h00;
		cap = 8'h00;
	end

	// ====================
	// Clock-out side
	// Rotation keeps the byte aligned and the line toggling
	always @(negedge sclk_dev_i) if (sclk_oe_i) begin
		rxd_o <= rot[0];
		rot <= {rot[0], rot[7:1]};
	end
	always @(posedge sclk_dev_i) if (sclk_oe_i) cap <= {txd_i, cap[7:1]};

	// ====================
	// Clock-in side
	// Clock stands still after the frame
	task automatic frame(input logic rise, input logic [7:0] d, output logic [7:0] got);
		for (int i = 0; i < 8; i++) begin
			sclk_o = ~rise;
			rxd_o = d[i];
			#80;
			if (i > 0) got[i-1] = txd_i;
			#80;
			sclk_o = rise;
			#160;
		end
		#80;
		got[7] = txd_i;
		rxd_o = ~d[7];
	endtask
endmodule

// File: dv/ssio_core_bench.sv
`timescale 1ns/1ps
module ssio_core_bench;
	logic                 clk_i = 1'b0;
	logic                 reset_i = 1'b1;
	ssio_pkg::ssio_cfg_t  cfg = '0;
	logic                 err_clr = 1'b0;
	ssio_pkg::ssio_stat_t stat;
	logic [7:0]           tx_d = 8'h00;
	logic                 tx_v = 1'b0;
	logic                 rx_rdy = 1'b0;
	logic                 tx_rdy, rx_v, tx_irq, rx_irq, sck_o, sck_oe, txd, sck_ext, rxd;
	logic [7:0]           rx_d, got;
	wire                  sck = sck_oe ? sck_o : sck_ext;
	int                   bad_count = 0, checked = 0, tx_n = 0, rx_n = 0, cyc = 0, t, r;

	always #20 clk_i = ~clk_i;

	ssio_core u_dut (.CLK_I(clk_i), .RESET_I(reset_i), .CFG_I(cfg), .ERR_CLEAR_I(err_clr),
		.STATUS_O(stat), .TX_DATA_I(tx_d), .TX_VALID_I(tx_v), .TX_READY_O(tx_rdy),
		.RX_DATA_O(rx_d), .RX_VALID_O(rx_v), .RX_READY_I(rx_rdy),
		.TRANSMIT_INTERRUPT_O(tx_irq), .RECEIVE_INTERRUPT_O(rx_irq),
		.SERIAL_CLOCK_PIN_I(sck), .SERIAL_CLOCK_PIN_O(sck_o),
		.SERIAL_CLOCK_PIN_OE_O(sck_oe), .TX_DATA_PIN_O(txd), .RX_DATA_PIN_I(rxd));
	ssio_peer u_peer (.sclk_dev_i(sck_o), .sclk_oe_i(sck_oe), .txd_i(txd),
		.sclk_o(sck_ext), .rxd_o(rxd));

	// ====================
	// Helpers
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (tx_irq === 1'b1) tx_n <= tx_n + 1;
		if (rx_irq === 1'b1) rx_n <= rx_n + 1;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cn(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic wr(input logic [7:0] d);
		int k;
		k = 0;
		while (tx_rdy !== 1'b1 && k < 500) begin
			@(negedge clk_i);
			k++;
		end
		if (k == 500) bad_count++;
		tx_d = d;
		tx_v = 1'b1;
		@(negedge clk_i);
		tx_v = 1'b0;
	endtask
	task automatic rd(input logic [7:0] exp);
		chk(rx_d, exp);
		rx_rdy = rx_v;
		@(negedge clk_i);
		rx_rdy = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic drain(input logic [7:0] exp);
		repeat (3) if (rx_v === 1'b1) rd(exp);
	endtask
	task automatic still(input int n);
		int z;
		z = 0;
		repeat (n) begin
			@(negedge clk_i);
			if (sck_o !== 1'b1) z++;
		end
		chk(8'(z), 8'h00);
	endtask
	task automatic snap;
		t = tx_n;
		r = rx_n;
	endtask

	// ====================
	// Scenarios
	task automatic s_tx_out;
		cfg = 5'h10;
		snap();
		wr(8'hA5);
		chk(8'(sck_oe), 8'h01);
		cn(100);
		chk(u_peer.cap, 8'hA5);
		chk(8'(tx_n - t), 8'h01);
		cfg = 5'h18;
		snap();
		wr(8'h3C);
		wr(8'h96);
		cn(200);
		chk(u_peer.cap, 8'h96);
		chk(8'(stat.tx_buffer_empty_flag), 8'h01);
		still(100);
		chk(8'(tx_n - t), 8'h02);
	endtask
	task automatic s_rx_out;
		u_peer.rot = 8'hC3;
		cfg = 5'h10;
		still(100);
		cfg = 5'h12;
		snap();
		cn(100);
		chk(8'(rx_n - r), 8'h01);
		still(100);
		rd(8'hC3);
		cn(100);
		chk(8'(rx_n - r), 8'h02);
		cfg = 5'h1A;
		snap();
		cn(300);
		chk(8'(rx_n - r), 8'h01);
		chk(8'(stat.rx_buffer_full_flag), 8'h01);
		still(100);
		rd(8'hC3);
		cn(3);
		chk(8'(rx_n - r), 8'h02);
		cfg = 5'h10;
		cn(150);
		drain(8'hC3);
	endtask
	task automatic s_fd_out;
		u_peer.rot = 8'h3C;
		cfg = 5'h16;
		snap();
		wr(8'h81);
		cn(100);
		chk(u_peer.cap, 8'h81);
		chk(8'(tx_n - t), 8'h01);
		chk(8'(rx_n - r), 8'h01);
		wr(8'h7E);
		still(100);
		rd(8'h3C);
		cn(100);
		chk(u_peer.cap, 8'h7E);
		drain(8'h3C);
		cfg = 5'h1E;
		snap();
		wr(8'h11);
		wr(8'h22);
		cn(250);
		chk(u_peer.cap, 8'h22);
		chk(8'(rx_n - r), 8'h02);
		still(100);
		drain(8'h3C);
	endtask
	task automatic s_in;
		cfg = 5'h06;
		wr(8'h4B);
		chk(8'(sck_oe), 8'h00);
		snap();
		u_peer.frame(1'b0, 8'hD2, got);
		cn(10);
		chk(got, 8'h4B);
		chk(8'(tx_n - t), 8'h01);
		chk(8'(rx_n - r), 8'h01);
		rd(8'hD2);
		cfg = 5'h07;
		wr(8'hB4);
		u_peer.frame(1'b1, 8'h2D, got);
		cn(10);
		chk(got, 8'hB4);
		rd(8'h2D);
		cfg = 5'h0F;
		u_peer.frame(1'b1, 8'h5A, got);
		cn(10);
		chk(got, 8'hFF);
		chk(8'(stat.underrun_error), 8'h01);
		cn(50);
		chk(8'(stat.underrun_error), 8'h01);
		err_clr = 1'b1;
		cn(1);
		err_clr = 1'b0;
		cn(1);
		chk(8'(stat.underrun_error), 8'h00);
		u_peer.frame(1'b1, 8'h66, got);
		u_peer.frame(1'b1, 8'h77, got);
		cn(10);
		chk(8'(stat.overrun_error), 8'h01);
		rd(8'h5A);
		rd(8'h66);
		chk(8'(rx_v), 8'h00);
	endtask

	initial begin
		repeat (4) @(negedge clk_i);
		reset_i = 1'b0;
		chk(8'(stat), 8'h08);
		chk(8'(tx_rdy), 8'h01);
		chk(8'(txd), 8'h01);
		chk(8'(sck_o), 8'h01);
		s_tx_out();
		s_rx_out();
		s_fd_out();
		s_in();
		close_out();
	end
endmodule
